// ===== shared/tcw_defines.svh
// Constants for the timer, counter and watchdog unit.
`ifndef TCW_DEFINES_SVH
`define TCW_DEFINES_SVH
`define TCW_MODE_13BIT 2'h0
`define TCW_MODE_16BIT 2'h1
`define TCW_MODE_RELOAD8 2'h2
`define TCW_MODE_SPLIT 2'h3
`define TCW_FUNC_BIT0 2
`define TCW_GATE_BIT0 3
`define TCW_FUNC_BIT1 6
`define TCW_GATE_BIT1 7
`define TCW_DIV12_LAST 2'h2
`define TCW_T13_MAX 13'h1FFF
`define TCW_T16_MAX 16'hFFFF
`define TCW_T8_MAX 8'hFF
`define TCW_WD_BASE_BITS 17
`define TCW_WD_STEP_BITS 3
`define TCW_WD_TAIL_LAST 10'h1FF
`define TCW_WD_RST_LAST 3'h7
`define TCW_CO_RATIO 2
`endif

// ===== shared/tcw_pkg.sv
// Types shared by the timer, counter and watchdog unit.
package tcw_pkg;
  typedef enum logic [1:0] {PH_C1 = 2'h0, PH_C2 = 2'h1, PH_C3 = 2'h3, PH_C4 = 2'h2} tcw_phase_t;
  typedef enum logic [1:0] {WD_OFF = 2'h0, WD_COUNT = 2'h1, WD_TAIL = 2'h3, WD_RESET = 2'h2} tcw_wd_state_t;
  typedef struct packed {
    logic capture_reload_select;
    logic down_count_enable;
    logic capture_clear;
    logic rx_baud_select;
    logic tx_baud_select;
    logic clock_out_enable;
    logic third_source_select;
    logic trigger_enable;
  } tcw_t2_cfg_t;
  typedef struct packed {
    logic restart;
    logic [1:0] interval;
    logic reset_enable;
    logic irq_enable;
    logic global_irq_enable;
    logic timeout_clear;
    logic cause_clear;
  } tcw_wd_ctl_t;
endpackage

// ===== logic/tcw_timer_unit.sv
// Timers 0, 1 and 2 with the watchdog divider.
`timescale 1ns/10ps
`include "tcw_defines.svh"
module tcw_timer_unit import tcw_pkg::*; #(
  parameter int WD_BASE_BITS = `TCW_WD_BASE_BITS
) (
  input wire logic CLOCK_I,
  input wire logic SRST_I,
  input wire logic [7:0] TIMER_MODE_REG_I,
  input wire logic TURBO_RATE_ZERO_I,
  input wire logic TURBO_RATE_ONE_I,
  input wire logic TURBO_RATE_TWO_I,
  input wire logic RUN_BIT_ZERO_I,
  input wire logic RUN_BIT_ONE_I,
  input wire logic RUN_BIT_TWO_I,
  input wire tcw_t2_cfg_t T2_CFG_I,
  input wire tcw_wd_ctl_t WD_CTL_I,
  input wire logic COUNT_PIN_ZERO_I,
  input wire logic COUNT_PIN_ONE_I,
  input wire logic COUNT_PIN_TWO_I,
  input wire logic EXT_IRQ_GATE_PIN_ZERO_I,
  input wire logic EXT_IRQ_GATE_PIN_ONE_I,
  input wire logic TRIGGER_PIN_I,
  input wire logic CNT0_WR_I,
  input wire logic [15:0] CNT0_WDATA_I,
  input wire logic CNT1_WR_I,
  input wire logic [15:0] CNT1_WDATA_I,
  input wire logic CNT2_WR_I,
  input wire logic [15:0] CNT2_WDATA_I,
  input wire logic CAP_WR_I,
  input wire logic [15:0] CAP_WDATA_I,
  input wire logic [2:0] OVF_CLR_I,
  input wire logic EXT_FLAG_CLR_I,
  output logic [15:0] COUNT0_O,
  output logic [15:0] COUNT1_O,
  output logic [15:0] COUNT2_O,
  output logic [15:0] CAPTURE_O,
  output logic [2:0] OVERFLOW_FLAG_O,
  output logic EXTERNAL_FLAG_O,
  output logic T1_OVF_TICK_O,
  output logic T2_BAUD_TICK_O,
  output logic T2_IRQ_O,
  output logic CLOCK_OUT_O,
  output logic WD_TIMEOUT_FLAG_O,
  output logic WD_RESET_CAUSE_FLAG_O,
  output logic WD_IRQ_O,
  output logic SYS_RESET_O
);
  tcw_phase_t phase, next_phase;
  logic [1:0] mc_cnt;
  logic [15:0] count0, count1, count2, cap, next_count0, next_count1, next_count2, next_cap;
  logic [16:0] st0, st1, co_cnt;
  logic tf0, tf1, tf2, exf, clk_out;
  logic smp0, smp1, smp2, smp_tr, edge0, edge1, edge2, edge_tr;
  logic upd, tb0, tb1, tb2, split0, en0, en1, step0, step1, step2;
  logic ovf0, ovf0h, ovf1, ovf2, set_tf2, set_exf, tog_exf, baud, co_mode, trig_act;
  logic [8:0] hi_sum;
  tcw_wd_state_t wd_state;
  logic [25:0] wd_cnt, tap_mask;
  logic [9:0] tail_cnt;
  logic [2:0] rst_cnt;
  logic [4:0] tap_shift;
  logic wd_timeout_flag, wd_reset_cause_flag, tap_hit;

  // Step of a 16-bit pair in modes 0..2; bit 16 is the overflow.
  function automatic logic [16:0] step01(input logic [1:0] mode, input logic [15:0] c);
    logic [13:0] v;
    logic [16:0] r;
    v = {1'b0, c[15:8], c[4:0]} + 14'h0001;
    r = {1'b0, c};
    unique case (mode)
      `TCW_MODE_13BIT: r = {v[13], v[12:5], c[7:5], v[4:0]};
      `TCW_MODE_16BIT: r = {1'b0, c} + 17'h0_0001;
      `TCW_MODE_RELOAD8: r = (c[7:0] == `TCW_T8_MAX) ? {1'b1, c[15:8], c[15:8]}
                                                      : {1'b0, c[15:8], c[7:0] + 8'h01};
      `TCW_MODE_SPLIT: r = {1'b0, c};
    endcase
    return r;
  endfunction

  always_comb begin
    unique case (phase)
      PH_C1: next_phase = PH_C2;
      PH_C2: next_phase = PH_C3;
      PH_C3: next_phase = PH_C4;
      PH_C4: next_phase = PH_C1;
    endcase
  end

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      phase <= PH_C1;
      mc_cnt <= 2'h0;
    end else begin
      phase <= next_phase;
      if (phase == PH_C4) begin
        mc_cnt <= (mc_cnt == `TCW_DIV12_LAST) ? 2'h0 : mc_cnt + 2'h1;
      end
    end
  end

  // Pins are sampled once per machine cycle; the edge stays valid through the next C3.
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      {smp0, smp1, smp2, smp_tr} <= 4'h0;
      {edge0, edge1, edge2, edge_tr} <= 4'h0;
    end else if (phase == PH_C4) begin
      {smp0, smp1, smp2, smp_tr} <= {COUNT_PIN_ZERO_I, COUNT_PIN_ONE_I, COUNT_PIN_TWO_I, TRIGGER_PIN_I};
      edge0 <= smp0 & ~COUNT_PIN_ZERO_I;
      edge1 <= smp1 & ~COUNT_PIN_ONE_I;
      edge2 <= smp2 & ~COUNT_PIN_TWO_I;
      edge_tr <= smp_tr & ~TRIGGER_PIN_I;
    end
  end

  assign upd = (phase == PH_C3);
  assign tb0 = TURBO_RATE_ZERO_I | (mc_cnt == 2'h0);
  assign tb1 = TURBO_RATE_ONE_I | (mc_cnt == 2'h0);
  assign tb2 = TURBO_RATE_TWO_I | (mc_cnt == 2'h0);
  assign split0 = (TIMER_MODE_REG_I[1:0] == `TCW_MODE_SPLIT);
  assign en0 = RUN_BIT_ZERO_I & (~TIMER_MODE_REG_I[`TCW_GATE_BIT0] | EXT_IRQ_GATE_PIN_ZERO_I);
  assign en1 = (split0 | RUN_BIT_ONE_I) & (~TIMER_MODE_REG_I[`TCW_GATE_BIT1] | EXT_IRQ_GATE_PIN_ONE_I);
  assign step0 = upd & en0 & (TIMER_MODE_REG_I[`TCW_FUNC_BIT0] ? edge0 : tb0);
  assign step1 = upd & en1 & (TIMER_MODE_REG_I[`TCW_FUNC_BIT1] ? edge1 : tb1);
  assign st0 = step01(TIMER_MODE_REG_I[1:0], count0);
  assign st1 = step01(TIMER_MODE_REG_I[5:4], count1);
  assign hi_sum = {1'b0, count0[15:8]} + 9'h001;

  always_comb begin
    next_count0 = count0;
    ovf0 = 1'b0;
    ovf0h = 1'b0;
    if (step0 && split0) begin
      next_count0[7:0] = count0[7:0] + 8'h01;
      ovf0 = (count0[7:0] == `TCW_T8_MAX);
    end else if (step0) begin
      {ovf0, next_count0} = st0;
    end
    if (upd && split0 && RUN_BIT_ONE_I && tb0) begin
      {ovf0h, next_count0[15:8]} = hi_sum;
    end
    if (CNT0_WR_I) begin
      next_count0 = CNT0_WDATA_I;
    end
  end

  always_comb begin
    next_count1 = count1;
    ovf1 = 1'b0;
    if (step1) begin
      {ovf1, next_count1} = st1;
    end
    if (CNT1_WR_I) begin
      next_count1 = CNT1_WDATA_I;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      count0 <= 16'h0000;
      count1 <= 16'h0000;
      tf0 <= 1'b0;
      tf1 <= 1'b0;
      T1_OVF_TICK_O <= 1'b0;
    end else begin
      count0 <= next_count0;
      count1 <= next_count1;
      tf0 <= (tf0 & ~OVF_CLR_I[0]) | ovf0;
      tf1 <= (tf1 & ~OVF_CLR_I[1]) | (ovf1 & ~split0) | ovf0h;
      T1_OVF_TICK_O <= ovf1;
    end
  end

  assign baud = T2_CFG_I.rx_baud_select | T2_CFG_I.tx_baud_select;
  assign co_mode = T2_CFG_I.clock_out_enable & ~T2_CFG_I.third_source_select & ~T2_CFG_I.capture_reload_select;
  assign step2 = upd & RUN_BIT_TWO_I & (T2_CFG_I.third_source_select ? edge2 : tb2);
  assign trig_act = upd & T2_CFG_I.trigger_enable & edge_tr;

  always_comb begin
    next_count2 = count2;
    next_cap = cap;
    ovf2 = 1'b0;
    set_tf2 = 1'b0;
    set_exf = 1'b0;
    tog_exf = 1'b0;
    if (step2) begin
      if (T2_CFG_I.capture_reload_select && !baud) begin
        next_count2 = count2 + 16'h0001;
        set_tf2 = (count2 == `TCW_T16_MAX);
      end else if (T2_CFG_I.down_count_enable && !baud && !co_mode && !smp_tr) begin
        next_count2 = (count2 == cap) ? `TCW_T16_MAX : count2 - 16'h0001;
        set_tf2 = (count2 == cap);
        tog_exf = set_tf2;
      end else begin
        ovf2 = (count2 == `TCW_T16_MAX);
        next_count2 = ovf2 ? cap : count2 + 16'h0001;
        set_tf2 = ovf2 & ~baud & ~co_mode;
        tog_exf = ovf2 & T2_CFG_I.down_count_enable & ~baud & ~co_mode;
      end
    end
    if (trig_act) begin
      if (T2_CFG_I.capture_reload_select && !baud) begin
        next_cap = count2;
        set_exf = 1'b1;
        if (T2_CFG_I.capture_clear) begin
          next_count2 = 16'h0000;
        end
      end else if (baud || co_mode) begin
        set_exf = 1'b1;
      end else if (!T2_CFG_I.down_count_enable) begin
        next_count2 = cap;
        set_exf = 1'b1;
      end
    end
    if (CNT2_WR_I) begin
      next_count2 = CNT2_WDATA_I;
    end
    if (CAP_WR_I) begin
      next_cap = CAP_WDATA_I;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      count2 <= 16'h0000;
      cap <= 16'h0000;
      tf2 <= 1'b0;
      exf <= 1'b0;
      T2_BAUD_TICK_O <= 1'b0;
    end else begin
      count2 <= next_count2;
      cap <= next_cap;
      tf2 <= (tf2 & ~OVF_CLR_I[2]) | set_tf2;
      exf <= ((exf & ~EXT_FLAG_CLR_I) | set_exf) ^ tog_exf;
      T2_BAUD_TICK_O <= ovf2 & baud;
    end
  end

  // The divider is independent of the count so that the output period is exact for any nonzero capture value; a zero capture value holds the output low.
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      co_cnt <= 17'h0_0000;
      clk_out <= 1'b0;
    end else if (co_mode && RUN_BIT_TWO_I && cap != 16'h0000) begin
      if (co_cnt >= ({1'b0, cap} * 17'(`TCW_CO_RATIO)) - 17'h0_0001) begin
        co_cnt <= 17'h0_0000;
        clk_out <= ~clk_out;
      end else begin
        co_cnt <= co_cnt + 17'h0_0001;
      end
    end else begin
      co_cnt <= 17'h0_0000;
      clk_out <= 1'b0;
    end
  end

  assign tap_shift = 5'(WD_BASE_BITS) + 5'(WD_CTL_I.interval) * 5'(`TCW_WD_STEP_BITS);
  assign tap_mask = 26'((27'h000_0001 << tap_shift) - 27'h000_0001);
  assign tap_hit = &(wd_cnt | ~tap_mask);

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      wd_state <= WD_OFF;
      wd_cnt <= 26'h000_0000;
      tail_cnt <= 10'h000;
      rst_cnt <= 3'h0;
    end else if (WD_CTL_I.restart) begin
      wd_state <= WD_COUNT;
      wd_cnt <= 26'h000_0000;
    end else begin
      unique case (wd_state)
        WD_OFF: wd_cnt <= 26'h000_0000;
        WD_COUNT, WD_TAIL: begin
          wd_cnt <= tap_hit ? 26'h000_0000 : wd_cnt + 26'h000_0001;
          tail_cnt <= (wd_state == WD_TAIL) ? tail_cnt + 10'h001 : 10'h000;
          if (tap_hit) begin
            wd_state <= WD_TAIL;
            tail_cnt <= 10'h000;
          end else if (wd_state == WD_TAIL && tail_cnt == `TCW_WD_TAIL_LAST) begin
            wd_state <= WD_CTL_I.reset_enable ? WD_RESET : WD_COUNT;
            rst_cnt <= 3'h0;
          end
        end
        WD_RESET: begin
          rst_cnt <= rst_cnt + 3'h1;
          if (rst_cnt == `TCW_WD_RST_LAST) begin
            wd_state <= WD_COUNT;
            wd_cnt <= 26'h000_0000;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      wd_timeout_flag <= 1'b0;
      wd_reset_cause_flag <= 1'b0;
    end else begin
      wd_timeout_flag <= (wd_timeout_flag & ~WD_CTL_I.timeout_clear) | (tap_hit & (wd_state inside {WD_COUNT, WD_TAIL}));
      wd_reset_cause_flag <= (wd_reset_cause_flag & ~WD_CTL_I.cause_clear) | (wd_state == WD_TAIL && tail_cnt == `TCW_WD_TAIL_LAST &&
              WD_CTL_I.reset_enable && !tap_hit && !WD_CTL_I.restart);
    end
  end

  assign COUNT0_O = count0;
  assign COUNT1_O = count1;
  assign COUNT2_O = count2;
  assign CAPTURE_O = cap;
  assign OVERFLOW_FLAG_O = {tf2, tf1, tf0};
  assign EXTERNAL_FLAG_O = exf;
  assign T2_IRQ_O = tf2 | (exf & ~(T2_CFG_I.down_count_enable & ~T2_CFG_I.capture_reload_select & ~baud));
  assign CLOCK_OUT_O = clk_out;
  assign WD_TIMEOUT_FLAG_O = wd_timeout_flag;
  assign WD_RESET_CAUSE_FLAG_O = wd_reset_cause_flag;
  assign WD_IRQ_O = wd_timeout_flag & WD_CTL_I.irq_enable & WD_CTL_I.global_irq_enable;
  assign SYS_RESET_O = (wd_state == WD_RESET);

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SRST_I);

  sequence s_wd_rst_pulse;
    SYS_RESET_O [*8] ##1 !SYS_RESET_O;
  endsequence

  a_update_at_c3: assert property ((count0 != $past(count0)) && !$past(CNT0_WR_I) |-> $past(phase) == PH_C3)
    else $error("Timer 0 count changed outside C3.");
  a_mode0_rollover: assert property (step0 && !CNT0_WR_I && TIMER_MODE_REG_I[1:0] == `TCW_MODE_13BIT &&
    {count0[15:8], count0[4:0]} == `TCW_T13_MAX |=> {count0[15:8], count0[4:0]} == 13'h0000 && tf0)
    else $error("Mode 0 rollover did not clear count and set flag.");
  a_mode1_rollover: assert property (step0 && !CNT0_WR_I && TIMER_MODE_REG_I[1:0] == `TCW_MODE_16BIT &&
    count0 == `TCW_T16_MAX |=> count0 == 16'h0000 && tf0)
    else $error("Mode 1 rollover did not clear count and set flag.");
  a_mode2_reload: assert property (step0 && !CNT0_WR_I && TIMER_MODE_REG_I[1:0] == `TCW_MODE_RELOAD8 &&
    count0[7:0] == `TCW_T8_MAX |=> count0[7:0] == $past(count0[15:8]) && count0[15:8] == $past(count0[15:8]))
    else $error("Mode 2 reload wrong.");
  a_gate_hold: assert property (!RUN_BIT_ZERO_I && !split0 && !CNT0_WR_I |=> count0 == $past(count0))
    else $error("Timer 0 counted while stopped.");
  a_t2_capture: assert property (trig_act && T2_CFG_I.capture_reload_select && !baud && !CAP_WR_I
    |=> cap == $past(count2) && exf)
    else $error("Capture did not copy count or set external flag.");
  a_baud_no_tf2: assert property (ovf2 && baud && !tf2 |=> !tf2)
    else $error("Baud mode overflow set the overflow flag.");
  a_wd_restart: assert property (WD_CTL_I.restart |=> wd_cnt == 26'h000_0000 && wd_state == WD_COUNT)
    else $error("Restart did not clear the watchdog divider.");
  a_wd_timeout_flag: assert property (tap_hit && wd_state != WD_OFF && wd_state != WD_RESET |=> wd_timeout_flag)
    else $error("Timeout did not set the timeout flag.");
  a_wd_reset_len: assert property ($rose(SYS_RESET_O) |-> s_wd_rst_pulse ##0 wd_reset_cause_flag)
    else $error("Watchdog reset pulse not eight clocks or cause flag missing.");
endmodule // tcw_timer_unit

// ===== bench/tcw_pins_model.sv
// Pin-side model: count pulses, gate levels, trigger pin and clock-out timing.
`timescale 1ns/10ps
module tcw_pins_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [7:0] pulses_i,
  input wire logic trig_i,
  input wire logic trig_lvl_i,
  input wire logic [1:0] gate_i,
  input wire logic clock_out_i,
  output logic cnt_pin_o,
  output logic trig_pin_o,
  output logic [1:0] gate_o,
  output logic busy_o,
  output logic [15:0] co_hi_o,
  output logic [15:0] co_lo_o
);
  logic [8:0] left = '0;
  logic [3:0] ph = '0;
  logic [3:0] tph = '0;
  logic [15:0] run = '0;
  logic co_q = 1'b0;
  initial co_hi_o = '0;
  initial co_lo_o = '0;
  assign busy_o = (left != 9'h000) || (tph != 4'h0);
  // Each level lasts two machine cycles so that every fall is seen by the C4 sampling.
  assign cnt_pin_o = !((left != 9'h000) && (ph < 4'h8));
  // The pin level gives the count direction outside a trigger pulse.
  assign trig_pin_o = (tph != 4'h0) ? 1'b0 : trig_lvl_i;
  assign gate_o = gate_i;
  always @(posedge clk_i) begin
    if (go_i) begin
      left <= {1'b0, pulses_i};
      ph <= '0;
    end else if (left != 9'h000) begin
      ph <= ph + 4'h1;
      if (ph == 4'hF) left <= left - 9'h001;
    end
    if (trig_i) tph <= 4'h1;
    else if (tph != 4'h0) tph <= tph + 4'h1;
    co_q <= clock_out_i;
    if (clock_out_i != co_q) begin
      run <= 16'h0001;
      if (co_q) co_hi_o <= run;
      else co_lo_o <= run;
    end else begin
      run <= run + 16'h0001;
    end
  end
endmodule // tcw_pins_model

// ===== bench/tb_top.sv
// Self-checking bench for the timer, counter and watchdog unit.
`timescale 1ns/10ps
module tb_top;
  import tcw_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] timer_mode_reg = '0;
  logic [2:0] tb = '0;
  logic [2:0] rn = '0;
  tcw_t2_cfg_t t2c = '0;
  tcw_wd_ctl_t wdc = '0;
  logic [1:0] gate = '0;
  logic wr = 1'b0;
  logic [15:0] d0 = '0, d1 = '0, d2 = '0, dp = '0;
  logic [2:0] oclr = '0;
  logic eclr = 1'b0, go = 1'b0, trg = 1'b0, tlvl = 1'b1;
  logic [7:0] npul = '0;
  logic [15:0] q0, q1, q2, qc, cohi, colo;
  logic [2:0] ovf;
  logic exf, t2irq, cko, wdf, wdcf, wdirq, sysr, cpin, tpin, busy;
  logic [1:0] gpin;
  logic [31:0] seed = 32'h0000_0003;
  int mismatches = 0;
  int num_checks = 0;
  int n;
  tcw_t2_cfg_t cf[6] = '{8'h80, 8'h00, 8'h40, 8'h40, 8'h10, 8'h08};
  logic [15:0] st[6] = '{16'hFFFE, 16'hFFFE, 16'h0011, 16'hFFFE, 16'hFFFE, 16'hFFFE};
  logic [15:0] pc[6] = '{16'h0000, 16'h1234, 16'h0010, 16'h1234, 16'h0100, 16'h0100};
  logic lv[6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
  logic [2:0] ef[6] = '{3'h6, 3'h6, 3'h7, 3'h7, 3'h0, 3'h0};
  tcw_t2_cfg_t ct[4] = '{8'h81, 8'hA1, 8'h01, 8'h09};
  logic [15:0] c2[4] = '{16'hBEEF, 16'h1357, 16'h0042, 16'h0042};
  logic [15:0] q2e[4] = '{16'hBEEF, 16'h0000, 16'h7777, 16'h0042};

  tcw_timer_unit #(.WD_BASE_BITS(4)) uut (
    .CLOCK_I(clk), .SRST_I(srst), .TIMER_MODE_REG_I(timer_mode_reg),
    .TURBO_RATE_ZERO_I(tb[0]), .TURBO_RATE_ONE_I(tb[1]), .TURBO_RATE_TWO_I(tb[2]),
    .RUN_BIT_ZERO_I(rn[0]), .RUN_BIT_ONE_I(rn[1]), .RUN_BIT_TWO_I(rn[2]), .T2_CFG_I(t2c), .WD_CTL_I(wdc),
    .COUNT_PIN_ZERO_I(cpin), .COUNT_PIN_ONE_I(cpin), .COUNT_PIN_TWO_I(cpin),
    .EXT_IRQ_GATE_PIN_ZERO_I(gpin[0]), .EXT_IRQ_GATE_PIN_ONE_I(gpin[1]), .TRIGGER_PIN_I(tpin),
    .CNT0_WR_I(wr), .CNT0_WDATA_I(d0), .CNT1_WR_I(wr), .CNT1_WDATA_I(d1), .CNT2_WR_I(wr), .CNT2_WDATA_I(d2),
    .CAP_WR_I(wr), .CAP_WDATA_I(dp), .OVF_CLR_I(oclr), .EXT_FLAG_CLR_I(eclr),
    .COUNT0_O(q0), .COUNT1_O(q1), .COUNT2_O(q2), .CAPTURE_O(qc), .OVERFLOW_FLAG_O(ovf),
    .EXTERNAL_FLAG_O(exf), .T1_OVF_TICK_O(), .T2_BAUD_TICK_O(), .T2_IRQ_O(t2irq), .CLOCK_OUT_O(cko),
    .WD_TIMEOUT_FLAG_O(wdf), .WD_RESET_CAUSE_FLAG_O(wdcf), .WD_IRQ_O(wdirq), .SYS_RESET_O(sysr));

  tcw_pins_model pins (.clk_i(clk), .go_i(go), .pulses_i(npul), .trig_i(trg), .trig_lvl_i(tlvl), .gate_i(gate),
    .clock_out_i(cko), .cnt_pin_o(cpin), .trig_pin_o(tpin), .gate_o(gpin), .busy_o(busy), .co_hi_o(cohi),
    .co_lo_o(colo));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // Steps a count k times, wrapping to the reload value when counting up and from the reload value to FFFF when counting down.
  function automatic logic [15:0] t2n(input logic [15:0] v, input logic [15:0] p, input int k, input logic dn);
    repeat (k) v = dn ? ((v == p) ? 16'hFFFF : v - 16'h0001) : ((v == 16'hFFFF) ? p : v + 16'h0001);
    return v;
  endfunction

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Whole edges are counted, then outputs are read at the falling edge once settled.
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic cfg(input logic [7:0] m, input logic [2:0] t, input logic [2:0] r, input tcw_t2_cfg_t c);
    @(posedge clk);
    timer_mode_reg <= m;
    tb <= t;
    rn <= r;
    t2c <= c;
  endtask

  // The write wins over counting in its cycle, so later tick counts are exact.
  task automatic load(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c, input logic [15:0] p);
    @(posedge clk);
    {d0, d1, d2, dp} <= {a, b, c, p};
    wr <= 1'b1;
    oclr <= 3'h7;
    eclr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    oclr <= 3'h0;
    eclr <= 1'b0;
  endtask

  task automatic wdst();
    @(posedge clk);
    wdc.restart <= 1'b1;
    wdc.timeout_clear <= 1'b1;
    wdc.cause_clear <= 1'b1;
    @(posedge clk);
    wdc.restart <= 1'b0;
    wdc.timeout_clear <= 1'b0;
    wdc.cause_clear <= 1'b0;
  endtask

  initial begin
    forever #20 clk = ~clk;
  end

  initial begin
    #(40 * 60000);
    mismatches++;
    stop_test();
  end

  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      n = 1 + seed[5:4];
      cfg(8'h11, {1'b0, ~seed[3], seed[3]}, 3'b011, '0);
      load(seed[15:0], seed[31:16], seed[15:0], 16'h0000);
      tick(12 * n);
      chk(q0, t2n(seed[15:0], '0, n * (seed[3] ? 3 : 1), 1'b0));
      chk(q1, t2n(seed[31:16], '0, n * (seed[3] ? 1 : 3), 1'b0));
      chk(q2, seed[15:0]);
    end
    @(posedge clk);
    gate <= 2'b10;
    cfg(8'h99, 3'b011, 3'b011, '0);
    load(16'h1000, 16'h2000, '0, '0);
    tick(12);
    chk(q0, 16'h1000);
    chk(q1, 16'h2003);
    cfg(8'h00, 3'b011, 3'b011, '0);
    load(16'hFF1E, 16'hFF1E, '0, '0);
    tick(12);
    chk({q0[15:8], q0[4:0]}, 13'h0001);
    chk(ovf[1:0], 2'b11);
    cfg(8'h22, 3'b011, 3'b011, '0);
    load(16'hA5FE, 16'h5AFE, '0, '0);
    tick(12);
    chk(q0, 16'hA5A6);
    chk(q1, 16'h5A5B);
    chk(ovf[1:0], 2'b11);
    for (int i = 0; i < 2; i++) begin
      cfg(i ? 8'h33 : 8'h13, 3'b011, 3'b010, '0);
      load(16'hFE10, 16'h0100, '0, '0);
      tick(12);
      chk(q0, 16'h0110);
      chk(q1, i ? 16'h0100 : 16'h0103);
      chk(ovf[1:0], 2'b10);
    end
    cfg(8'h55, 3'b000, 3'b111, 8'h02);
    load('0, '0, '0, '0);
    seed = xs(seed);
    @(posedge clk);
    npul <= 8'(3 + seed[2:0]);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    for (n = 0; n < 400 && busy !== 1'b0; n++) @(posedge clk);
    tick(16);
    chk(q0, 16'(3 + seed[2:0]));
    chk(q1, 16'(3 + seed[2:0]));
    chk(q2, 16'(3 + seed[2:0]));
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      tlvl <= lv[i];
      cfg(8'h00, 3'b100, 3'b100, cf[i]);
      load('0, '0, st[i], pc[i]);
      tick(12);
      chk(q2, t2n(st[i], pc[i], 3, ~lv[i]));
      chk({ovf[2], t2irq, exf}, ef[i]);
    end
    for (int i = 0; i < 4; i++) begin
      cfg(8'h00, 3'b000, 3'b000, ct[i]);
      load('0, '0, c2[i], i > 1 ? 16'h7777 : 16'h0000);
      @(posedge clk);
      trg <= 1'b1;
      @(posedge clk);
      trg <= 1'b0;
      tick(24);
      chk(qc, i > 1 ? 16'h7777 : c2[i]);
      chk(q2, q2e[i]);
      chk({exf, t2irq}, 2'b11);
    end
    seed = xs(seed);
    cfg(8'h00, 3'b000, 3'b100, 8'h04);
    load('0, '0, '0, 16'(2 + seed[2:0]));
    tick(16 * (2 + seed[2:0]) + 8);
    chk(cohi, 16'(4 + 2 * seed[2:0]));
    chk(colo, 16'(4 + 2 * seed[2:0]));
    for (int s = 0; s < 4; s++) begin
      @(posedge clk);
      wdc.interval <= 2'(s);
      wdc.irq_enable <= s[0];
      wdc.global_irq_enable <= s[1];
      wdst();
      tick(8 << (3 * s));
      wdst();
      tick((16 << (3 * s)) - 4);
      chk({wdf, wdirq}, 2'b00);
      tick(7);
      chk({wdf, wdirq}, {1'b1, s == 3});
    end
    @(posedge clk);
    // The longest interval is used, because a shortened interval under 512 clocks restarts the tail on each timeout.
    wdc <= 8'h70;
    wdst();
    tick(8192 + 510);
    chk(sysr, 1'b0);
    for (n = 0; n < 30 && sysr !== 1'b1; n++) tick(0);
    for (n = 0; n < 20 && sysr === 1'b1; n++) tick(0);
    chk(16'(n), 16'h0008);
    chk(wdcf, 1'b1);
    @(posedge clk);
    wdc.reset_enable <= 1'b0;
    wdc.interval <= 2'h0;
    wdst();
    for (n = 0; n < 600 && sysr !== 1'b1; n++) tick(0);
    chk({sysr, wdcf, wdf}, 3'b001);
    stop_test();
  end
endmodule // tb_top
